// [scc_command_regs.sv]
`timescale 1ns/10ps

// Summary of operation
// R1 - eight-bit command register, zero at reset, holds target address for accesses
// R2 - any received byte with top bit set is taken as a command byte
// R3 - command bits 6:5 pick byte, word or block transfers
// R4 - transfer type 11 pulses an interrupt clear and is not stored
// R5 - command bits 4:0 select the register for later reads and writes
// R6 - each read request returns the register at the stored select address
// R7 - plain block transfers run until the host issues a stop
// R8 - bus block transfers carry a byte count, ignored on writes
// R9 - all eight channel bytes 10h to 17h readable in one transfer
// R10 - block command CFh makes the device send a byte count of eight first
// R11 - host never writes while the block alias address is selected
// R12 - host clears interrupts only with a send-byte interrupt clear command
// R13 - control bit 4 is a read-only flag set when integration completes
// R14 - control bit 1 enables or disables all four converter channels
// R15 - control bit 0 switches the device on or off
// R16 - converters run only while power and converter enable are both set
// R17 - host should program timing before setting converter enable
// R18 - writing 03h to control reads back as 03h; here bit 4 also reads back once a conversion has completed, giving 13h
// R19 - oscillator runs during any register access regardless of power bit
// R20 - host writes zero to reserved control bits
// R21 - timing settings shared by all channels, zero at reset
// R22 - word and block transfers advance the select address after each byte
module scc_command_regs #(
  parameter int unsigned CHAN_BYTES = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire scc_pkg::scc_bus_in_s bus_in,
  input wire logic adc_done,
  input wire logic [8*CHAN_BYTES-1:0] chan_data,
  output scc_pkg::scc_answer_s answer,
  output logic int_clear,
  output logic power_on,
  output logic adc_run,
  output logic osc_en,
  output scc_pkg::scc_timing_s timing
);

  generate
    if (CHAN_BYTES != scc_pkg::BLOCK_BYTES) begin : g_bad_width
      $error("channel block must be exactly eight bytes");
    end
  endgenerate

  logic [7:0] cmd_reg;
  scc_pkg::scc_state_e state_reg;
  logic count_pending_reg;
  logic access_reg;
  logic power_reg;
  logic adc_en_reg;
  logic adc_valid_reg;
  scc_pkg::scc_timing_s timing_reg;
  logic [8*CHAN_BYTES-1:0] shadow_reg;
  scc_pkg::scc_answer_s answer_reg;
  logic int_clear_reg;
  logic adc_run_reg;
  logic osc_en_reg;

  // decode of the incoming byte and the stored command
  logic is_cmd;
  logic is_clear;
  logic data_wr;
  logic rd;
  logic auto_inc;
  logic ctrl_wr;
  logic timing_wr;
  scc_pkg::scc_trans_e rx_trans;
  scc_pkg::scc_trans_e cur_trans;
  logic [4:0] cur_addr;
  logic [4:0] next_addr;

  assign rx_trans = scc_pkg::scc_trans_e'(
    bus_in.rx_byte[scc_pkg::CMD_TRANS_MSB:scc_pkg::CMD_TRANS_LSB]);
  assign cur_trans = scc_pkg::scc_trans_e'(
    cmd_reg[scc_pkg::CMD_TRANS_MSB:scc_pkg::CMD_TRANS_LSB]);
  assign cur_addr = cmd_reg[scc_pkg::CMD_ADDR_MSB:0]; // R5
  assign next_addr = 5'(cur_addr + 5'h01);
  assign is_cmd = bus_in.rx_valid && bus_in.rx_byte[scc_pkg::CMD_FLAG_BIT]; // R2
  assign is_clear = is_cmd && (rx_trans == scc_pkg::SCC_TRANS_INT_CLEAR); // R4
  assign data_wr = bus_in.rx_valid && !bus_in.rx_byte[scc_pkg::CMD_FLAG_BIT]
    && (state_reg != scc_pkg::SCC_ST_SKIP_COUNT); // R8
  assign rd = bus_in.tx_req;
  assign auto_inc = (cur_trans == scc_pkg::SCC_TRANS_WORD)
    || (cur_trans == scc_pkg::SCC_TRANS_BLOCK); // R3
  assign ctrl_wr = data_wr && (cur_addr == scc_pkg::ADDR_CONTROL);
  assign timing_wr = data_wr && (cur_addr == scc_pkg::ADDR_TIMING);

  // register read mux
  function automatic logic [7:0] read_value(input logic [4:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == scc_pkg::ADDR_CONTROL) begin
      v[scc_pkg::CTRL_POWER_BIT] = power_reg;
      v[scc_pkg::CTRL_ADC_EN_BIT] = adc_en_reg;
      v[scc_pkg::CTRL_VALID_BIT] = adc_valid_reg;
    end else if (a == scc_pkg::ADDR_TIMING) begin
      v = timing_reg;
    end else if ((a >= scc_pkg::ADDR_DATA_FIRST) && (a <= scc_pkg::ADDR_DATA_LAST)) begin
      v = shadow_reg[8*a[2:0] +: 8];
    end
    return v;
  endfunction

  // transaction phase
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= scc_pkg::SCC_ST_IDLE;
    end else begin
      case (state_reg)
        scc_pkg::SCC_ST_IDLE: begin
          if (bus_in.start) begin
            state_reg <= scc_pkg::SCC_ST_ACTIVE;
          end
        end
        scc_pkg::SCC_ST_ACTIVE: begin
          if (bus_in.stop) begin
            state_reg <= scc_pkg::SCC_ST_IDLE; // R7
          end else if (is_cmd && (rx_trans == scc_pkg::SCC_TRANS_BLOCK)) begin
            state_reg <= scc_pkg::SCC_ST_SKIP_COUNT; // R8
          end
        end
        scc_pkg::SCC_ST_SKIP_COUNT: begin
          if (bus_in.stop) begin
            state_reg <= scc_pkg::SCC_ST_IDLE;
          end else if (bus_in.start || bus_in.rx_valid) begin
            state_reg <= scc_pkg::SCC_ST_ACTIVE; // R8
          end
        end
        default: begin
          state_reg <= scc_pkg::SCC_ST_IDLE;
        end
      endcase
    end
  end

  // access in progress, keeps the oscillator alive
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      access_reg <= 1'b0;
    end else if (bus_in.stop) begin
      access_reg <= 1'b0;
    end else if (bus_in.start) begin
      access_reg <= 1'b1;
    end
  end

  // command byte store and address advance
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_reg <= scc_pkg::CMD_RESET; // R1
    end else if (is_cmd && !is_clear) begin
      cmd_reg <= bus_in.rx_byte; // R1
    end else if (rd && count_pending_reg) begin
      cmd_reg[scc_pkg::CMD_ADDR_MSB:0] <= scc_pkg::ADDR_DATA_FIRST; // R9
    end else if ((data_wr || rd) && auto_inc) begin
      cmd_reg[scc_pkg::CMD_ADDR_MSB:0] <= next_addr; // R22
    end
  end

  // byte count owed ahead of the channel block
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_pending_reg <= 1'b0;
    end else if (is_cmd) begin
      count_pending_reg <= (rx_trans == scc_pkg::SCC_TRANS_BLOCK)
        && (bus_in.rx_byte[scc_pkg::CMD_ADDR_MSB:0] == scc_pkg::ADDR_BLOCK_ALIAS); // R10
    end else if (rd) begin
      count_pending_reg <= 1'b0;
    end
  end

  // one-shot interrupt clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      int_clear_reg <= 1'b0;
    end else begin
      int_clear_reg <= is_clear; // R4
    end
  end

  // control register writable bits
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      power_reg <= scc_pkg::CTRL_RESET[scc_pkg::CTRL_POWER_BIT];
      adc_en_reg <= scc_pkg::CTRL_RESET[scc_pkg::CTRL_ADC_EN_BIT];
    end else if (ctrl_wr) begin
      power_reg <= bus_in.rx_byte[scc_pkg::CTRL_POWER_BIT]; // R15
      adc_en_reg <= bus_in.rx_byte[scc_pkg::CTRL_ADC_EN_BIT]; // R14
    end
  end

  // conversion complete flag, set wins over clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      adc_valid_reg <= scc_pkg::CTRL_RESET[scc_pkg::CTRL_VALID_BIT];
    end else if (adc_done && adc_run_reg) begin
      adc_valid_reg <= 1'b1; // R13
    end else if (ctrl_wr && !(bus_in.rx_byte[scc_pkg::CTRL_POWER_BIT]
        && bus_in.rx_byte[scc_pkg::CTRL_ADC_EN_BIT])) begin
      adc_valid_reg <= 1'b0;
    end
  end

  // shared timing settings
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timing_reg <= scc_pkg::TIMING_RESET; // R21
    end else if (timing_wr) begin
      timing_reg <= bus_in.rx_byte & scc_pkg::TIMING_WR_MASK; // R21
    end
  end

  // channel snapshot frozen during an access so the block is coherent
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shadow_reg <= '0;
    end else if (adc_done && !access_reg) begin
      shadow_reg <= chan_data; // R9
    end
  end

  // read answer, one cycle after the request
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      answer_reg <= '0;
    end else begin
      answer_reg.valid <= rd; // R6
      if (rd && count_pending_reg) begin
        answer_reg.data <= scc_pkg::BLOCK_COUNT; // R10
      end else if (rd) begin
        answer_reg.data <= read_value(cur_addr); // R6
      end
    end
  end

  // converter run and oscillator enable
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      adc_run_reg <= 1'b0;
      osc_en_reg <= 1'b0;
    end else begin
      adc_run_reg <= power_reg && adc_en_reg; // R16
      osc_en_reg <= power_reg || access_reg; // R19
    end
  end

  assign answer = answer_reg;
  assign int_clear = int_clear_reg;
  assign power_on = power_reg;
  assign adc_run = adc_run_reg;
  assign osc_en = osc_en_reg;
  assign timing = timing_reg;

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_cmd_store;
    is_cmd && !is_clear |=> cmd_reg == $past(bus_in.rx_byte);
  endproperty
  a_cmd_store: assert property (p_cmd_store) else $error("command byte not stored"); // R1

  sequence s_clear_cmd;
    is_clear;
  endsequence
  sequence s_clear_effect;
    int_clear && (cmd_reg == $past(cmd_reg)) ##1 (!int_clear || $past(is_clear));
  endsequence
  property p_int_clear;
    s_clear_cmd |=> s_clear_effect;
  endproperty
  a_int_clear: assert property (p_int_clear) else $error("interrupt clear not one-shot"); // R4

  property p_answer;
    rd && !count_pending_reg |=> answer.valid && answer.data == $past(read_value(cur_addr));
  endproperty
  a_answer: assert property (p_answer) else $error("read answer wrong"); // R6

  sequence s_count_read;
    count_pending_reg && rd;
  endsequence
  sequence s_count_answer;
    answer.valid && (answer.data == scc_pkg::BLOCK_COUNT)
      && (cmd_reg[scc_pkg::CMD_ADDR_MSB:0] == scc_pkg::ADDR_DATA_FIRST);
  endsequence
  property p_block_count;
    s_count_read |=> s_count_answer;
  endproperty
  a_block_count: assert property (p_block_count) else $error("byte count not inserted"); // R10

  property p_auto_inc;
    (data_wr || (rd && !count_pending_reg)) && auto_inc && !is_cmd
      |=> cmd_reg[scc_pkg::CMD_ADDR_MSB:0] == 5'($past(cur_addr) + 5'h01);
  endproperty
  a_auto_inc: assert property (p_auto_inc) else $error("address did not advance"); // R22

  property p_byte_hold;
    (data_wr || rd) && (cur_trans == scc_pkg::SCC_TRANS_BYTE) && !count_pending_reg && !is_cmd
      |=> $stable(cmd_reg);
  endproperty
  a_byte_hold: assert property (p_byte_hold) else $error("byte mode moved address"); // R3

  property p_skip_count;
    state_reg == scc_pkg::SCC_ST_SKIP_COUNT && bus_in.rx_valid && !is_cmd && !bus_in.stop
      |=> $stable(cmd_reg) && $stable(timing_reg) && state_reg == scc_pkg::SCC_ST_ACTIVE;
  endproperty
  a_skip_count: assert property (p_skip_count) else $error("byte count not skipped"); // R8

  property p_ctrl_write;
    ctrl_wr |=> power_reg == $past(bus_in.rx_byte[0]) && adc_en_reg == $past(bus_in.rx_byte[1]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost"); // R15 R14

  property p_run;
    adc_run |-> $past(power_reg) && $past(adc_en_reg);
  endproperty
  a_run: assert property (p_run) else $error("converter runs without power and enable"); // R16

  property p_valid_set;
    adc_done && adc_run_reg |=> adc_valid_reg;
  endproperty
  a_valid_set: assert property (p_valid_set) else $error("completion flag missed"); // R13

  property p_readback;
    ctrl_wr && (bus_in.rx_byte == 8'h03)
      |=> (read_value(scc_pkg::ADDR_CONTROL) & 8'hEF) == 8'h03;
  endproperty
  a_readback: assert property (p_readback) else $error("control readback not 03h"); // R18

  property p_osc;
    access_reg |=> osc_en;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator off during access"); // R19

  property p_timing;
    timing_wr |=> timing == ($past(bus_in.rx_byte) & scc_pkg::TIMING_WR_MASK);
  endproperty
  a_timing: assert property (p_timing) else $error("timing write lost"); // R21

endmodule

// [scc_pkg.sv]
package scc_pkg;

  // register select addresses
  localparam logic [4:0] ADDR_CONTROL = 5'h00;
  localparam logic [4:0] ADDR_TIMING = 5'h01;
  localparam logic [4:0] ADDR_BLOCK_ALIAS = 5'h0F;
  localparam logic [4:0] ADDR_DATA_FIRST = 5'h10;
  localparam logic [4:0] ADDR_DATA_LAST = 5'h17;

  // command byte layout
  localparam int CMD_FLAG_BIT = 7;
  localparam int CMD_TRANS_MSB = 6;
  localparam int CMD_TRANS_LSB = 5;
  localparam int CMD_ADDR_MSB = 4;
  localparam logic [7:0] CMD_RESET = 8'h00;

  // control register layout
  localparam int CTRL_POWER_BIT = 0;
  localparam int CTRL_ADC_EN_BIT = 1;
  localparam int CTRL_VALID_BIT = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // timing register: bit 7 is reserved and held at zero
  localparam logic [7:0] TIMING_WR_MASK = 8'h7F;
  localparam logic [7:0] TIMING_RESET = 8'h00;

  // byte count inserted ahead of the channel data block
  localparam logic [7:0] BLOCK_COUNT = 8'h08;
  localparam int BLOCK_BYTES = 8;

  typedef enum logic [1:0] {
    SCC_TRANS_BYTE = 2'b00,
    SCC_TRANS_WORD = 2'b01,
    SCC_TRANS_BLOCK = 2'b10,
    SCC_TRANS_INT_CLEAR = 2'b11
  } scc_trans_e;

  typedef enum logic [1:0] {
    SCC_ST_IDLE = 2'b00,
    SCC_ST_ACTIVE = 2'b01,
    SCC_ST_SKIP_COUNT = 2'b10
  } scc_state_e;

  // byte-level events from the serial bus engine
  typedef struct packed {
    logic start;
    logic stop;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic tx_req;
  } scc_bus_in_s;

  // byte handed back to the serial bus engine
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } scc_answer_s;

  typedef struct packed {
    logic reserved;
    logic sync_edge;
    logic [1:0] integration_mode_field;
    logic [3:0] time_param;
  } scc_timing_s;

endpackage

// [scc_host_model.sv]
`timescale 1ns/10ps
module scc_host_model (
  input wire logic clk,
  input wire logic reset_n,
  output scc_pkg::scc_bus_in_s bus_in,
  input wire scc_pkg::scc_answer_s answer
);
  initial bus_in = '0;

  // one-cycle strobe; the byte lane shows the inverse once released
  task automatic ev(input logic [2:0] kind, input logic [7:0] b, input logic tx);
    wait (reset_n);
    @(posedge clk);
    bus_in <= {kind, b, tx};
    @(posedge clk);
    bus_in <= {3'b000, ~b, 1'b0};
  endtask

  task automatic open_access();
    ev(3'b100, 8'h00, 1'b0);
  endtask

  // stop ends every transfer, block ones included
  task automatic close_access();
    ev(3'b010, 8'h00, 1'b0);
  endtask

  task automatic cmd(input logic [7:0] c);
    ev(3'b001, {1'b1, c[6:0]}, 1'b0);
  endtask

  task automatic data(input logic [7:0] d);
    ev(3'b001, d, 1'b0);
  endtask

  task automatic read(output logic [7:0] d, output logic v);
    ev(3'b000, 8'h00, 1'b1);
    @(posedge clk);
    v = answer.valid;
    d = answer.data;
  endtask

  // write byte protocol; never aimed at the block alias
  task automatic write_reg(input logic [4:0] a, input logic [7:0] d);
    if (a != scc_pkg::ADDR_BLOCK_ALIAS) begin
      open_access();
      cmd({3'b100, a});
      data(a == scc_pkg::ADDR_CONTROL ? (d & 8'h13) : d);
      close_access();
    end
  endtask

  task automatic read_reg(input logic [4:0] a, output logic [7:0] d, output logic v);
    open_access();
    cmd({3'b100, a});
    open_access();
    read(d, v);
    close_access();
  endtask
endmodule

// [scc_command_regs_tb_top.sv]
`timescale 1ns/10ps
module scc_command_regs_tb_top;
  logic clk;
  logic reset_n;
  logic adc_done;
  logic [63:0] chan_data;
  scc_pkg::scc_bus_in_s bus_in;
  scc_pkg::scc_answer_s answer;
  logic int_clear;
  logic power_on;
  logic adc_run;
  logic osc_en;
  scc_pkg::scc_timing_s timing;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  logic [7:0] rd;
  logic rv;

  scc_command_regs #(.CHAN_BYTES(8)) scc_command_regs_inst (.clk(clk), .reset_n(reset_n),
    .bus_in(bus_in), .adc_done(adc_done), .chan_data(chan_data), .answer(answer),
    .int_clear(int_clear), .power_on(power_on), .adc_run(adc_run), .osc_en(osc_en),
    .timing(timing));

  scc_host_model scc_host_model_inst (.clk(clk), .reset_n(reset_n), .bus_in(bus_in),
    .answer(answer));

  initial clk = 1'b0;
  always #10 clk = ~clk;

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic expect_reg(input logic [4:0] a, input logic [7:0] exp);
    scc_host_model_inst.read_reg(a, rd, rv);
    check("answer_valid", {7'h00, rv}, 8'h01);
    check("reg_read", rd, exp);
  endtask

  task automatic bare_read(input logic [7:0] exp);
    scc_host_model_inst.open_access();
    scc_host_model_inst.read(rd, rv);
    scc_host_model_inst.close_access();
    check("bare_read", rd, exp);
  endtask

  task automatic test_reset();
    check("int_clear", {7'h00, int_clear}, 8'h00);
    check("power_on", {7'h00, power_on}, 8'h00);
    check("timing", timing, scc_pkg::TIMING_RESET);
    bare_read(scc_pkg::CTRL_RESET);
    expect_reg(5'h05, 8'h00);
    $display("test reset done");
  endtask

  task automatic test_ctrl();
    scc_host_model_inst.write_reg(scc_pkg::ADDR_TIMING, 8'h12);
    scc_host_model_inst.write_reg(scc_pkg::ADDR_CONTROL, 8'h03);
    check("power_on", {7'h00, power_on}, 8'h01);
    check("adc_run", {7'h00, adc_run}, 8'h01);
    expect_reg(scc_pkg::ADDR_CONTROL, 8'h03);
    scc_host_model_inst.write_reg(scc_pkg::ADDR_CONTROL, 8'h01);
    check("adc_run", {7'h00, adc_run}, 8'h00);
    $display("test control done");
  endtask

  // word stream, then a flagged byte turns into a byte-type command
  task automatic test_word();
    scc_host_model_inst.open_access();
    scc_host_model_inst.cmd(8'hA0);
    scc_host_model_inst.data(8'h03);
    scc_host_model_inst.data(8'h35);
    scc_host_model_inst.data(8'h81);
    scc_host_model_inst.data(8'h44);
    scc_host_model_inst.data(8'h66);
    scc_host_model_inst.close_access();
    check("timing", timing, 8'h66);
    expect_reg(scc_pkg::ADDR_CONTROL, 8'h03);
    $display("test word done");
  endtask

  task automatic test_int();
    scc_host_model_inst.open_access();
    scc_host_model_inst.cmd(8'h81);
    scc_host_model_inst.cmd(8'hE0);
    #1 check("int_clear", {7'h00, int_clear}, 8'h01);
    @(posedge clk);
    #1 check("int_clear", {7'h00, int_clear}, 8'h00);
    scc_host_model_inst.close_access();
    bare_read(8'h66);
    $display("test interrupt clear done");
  endtask

  task automatic test_block();
    @(posedge clk);
    adc_done <= 1'b1;
    chan_data <= 64'hA7A6_A5A4_A3A2_A1A0;
    @(posedge clk);
    adc_done <= 1'b0;
    chan_data <= 64'h0000_0000_0000_0000;
    expect_reg(scc_pkg::ADDR_CONTROL, 8'h13);
    scc_host_model_inst.open_access();
    scc_host_model_inst.cmd(8'hCF);
    scc_host_model_inst.open_access();
    // a completion inside the access must not disturb the block
    adc_done <= 1'b1;
    chan_data <= 64'h5B5C_5D5E_5F50_5152;
    @(posedge clk);
    adc_done <= 1'b0;
    scc_host_model_inst.read(rd, rv);
    check("byte_count", rd, scc_pkg::BLOCK_COUNT);
    for (int k = 0; k < 8; k++) begin
      scc_host_model_inst.read(rd, rv);
      check("block_byte", rd, 8'hA0 + 8'(k));
    end
    scc_host_model_inst.close_access();
    adc_done <= 1'b1;
    @(posedge clk);
    adc_done <= 1'b0;
    expect_reg(scc_pkg::ADDR_DATA_FIRST, 8'h52);
    expect_reg(scc_pkg::ADDR_DATA_LAST, 8'h5B);
    $display("test block read done");
  endtask

  task automatic test_block_write();
    scc_host_model_inst.open_access();
    scc_host_model_inst.cmd(8'hC1);
    scc_host_model_inst.data(8'h05);
    scc_host_model_inst.data(8'h2A);
    scc_host_model_inst.close_access();
    check("timing", timing, 8'h2A);
    $display("test block write done");
  endtask

  task automatic test_power();
    scc_host_model_inst.write_reg(scc_pkg::ADDR_CONTROL, 8'h10);
    check("power_on", {7'h00, power_on}, 8'h00);
    expect_reg(scc_pkg::ADDR_CONTROL, 8'h00);
    repeat (3) @(posedge clk);
    #1 check("osc_en", {7'h00, osc_en}, 8'h00);
    scc_host_model_inst.open_access();
    repeat (2) @(posedge clk);
    #1 check("osc_en", {7'h00, osc_en}, 8'h01);
    scc_host_model_inst.close_access();
    $display("test power done");
  endtask

  task automatic test_mid_reset();
    scc_host_model_inst.write_reg(scc_pkg::ADDR_TIMING, 8'h5A);
    scc_host_model_inst.write_reg(scc_pkg::ADDR_CONTROL, 8'h03);
    check("timing", timing, 8'h5A);
    reset_n <= 1'b0;
    @(posedge clk);
    #1 check("power_on", {7'h00, power_on}, 8'h00);
    check("adc_run", {7'h00, adc_run}, 8'h00);
    check("osc_en", {7'h00, osc_en}, 8'h00);
    check("timing", timing, scc_pkg::TIMING_RESET);
    @(posedge clk);
    reset_n <= 1'b1;
    expect_reg(scc_pkg::ADDR_TIMING, scc_pkg::TIMING_RESET);
    expect_reg(scc_pkg::ADDR_CONTROL, scc_pkg::CTRL_RESET);
    $display("test mid-run reset done");
  endtask

  initial begin
    reset_n = 1'b0;
    adc_done = 1'b0;
    chan_data = '0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    test_reset();
    test_ctrl();
    test_word();
    test_int();
    test_block();
    test_block_write();
    test_power();
    test_mid_reset();
    wrap_up();
  end
endmodule
